// ### common/dlcs_defs.vh
// register offsets, field positions and reset values of the data link channel select block
`ifndef DLCS_DEFS_VH
`define DLCS_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DLCS_ADDR_RX_CTL 8'h90
`define DLCS_ADDR_RX_MASK 8'h91
`define DLCS_ADDR_TX_CTL 8'h92
`define DLCS_ADDR_TX_MASK 8'h93
`define DLCS_ADDR_RX_BUF 8'h28
`define DLCS_ADDR_MATCH_A 8'h29
`define DLCS_ADDR_MATCH_B 8'h2a
`define DLCS_ADDR_STATUS2 8'h17
`define DLCS_ADDR_IRQMASK2 8'h1b
`define DLCS_ADDR_COMMON2 8'h1a

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DLCS_CTL_LINK_EN 7
`define DLCS_CTL_PICK_MODE 5
`define DLCS_CTL_NUM_MSB 4
`define DLCS_CTL_NUM_LSB 0
`define DLCS_ST_BUF_FULL 4
`define DLCS_ST_MATCH 2
`define DLCS_CC_DESTUFF 0

// ------------------------------------------------------------
// reset values, control write mask and counts
// ------------------------------------------------------------
`define DLCS_RST_BYTE 8'h00
`define DLCS_CTL_WMASK 8'hbf
`define DLCS_BYTE_BITS 4'h8
`define DLCS_STUFF_RUN 3'h5
`define DLCS_RUN_SAT 3'h7
`define DLCS_FIFO_DEPTH 8
`define DLCS_FIFO_AW 3

`endif

// ### hdl/dlcs_top.v
// data link channel select, legacy receive link buffer and its byte fifo
`include "dlcs_defs.vh"

// ------------------------------------------------------------
// byte fifo
// ------------------------------------------------------------
module dlcs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `DLCS_FIFO_DEPTH,
    parameter AW = `DLCS_FIFO_AW
) (
    input wire clk_in,
    input wire nrst_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready_out = (count_r != DEPTH[AW:0]);
    assign out_valid_out = (count_r != {(AW+1){1'b0}});
    assign out_data_out = mem_r[rd_ptr_r];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // storage needs no reset; only written entries are ever read
    always @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end
endmodule

// What this block does
// [R01] receive link enable picks facility data link or DS0 channels for receive HDLC.
// [R02] receive pick mode: single channel number or channel-block map.
// [R03] receive channel number sits in control bits 4 down to 0.
// [R04] receive mask bit set excludes that DS0 bit; bit 7 is channel bit 8.
// [R05] transmit link enable puts HDLC output in data link or DS0 channels.
// [R06] transmit pick mode: single channel number or channel-block map.
// [R07] transmit channel number sits in control bits 4 down to 0.
// [R08] transmit mask bit set keeps that DS0 bit free of HDLC data.
// [R09] legacy receive buffer and HDLC receiver both see incoming link data.
// [R10] only one source drives the outgoing data link at a time.
// [R11] link bits shift one per frame into an eight-bit receive buffer.
// [R12] full buffer sets status bit 4; interrupt low if mask bit 4 set.
// [R13] host reads the buffer within 2 ms or the next byte overwrites it.
// [R14] completed byte equal to a match byte sets status bit 2, interrupts if enabled.
// [R15] with destuffer on, a zero after exactly five ones is deleted.
// [R16] a zero after six or more ones is kept.
// [R17] software should keep the destuffer on when extracting the data link.
// [R18] receive buffer holds the first received bit in its lsb.
// [R19] two eight-bit match registers hold the comparison bytes.
// [R20] control register writes take effect at the next frame boundary.
module dlcs_top (
    input wire clk_in,
    input wire nrst_in,
    input wire [7:0] cpu_addr_in,
    input wire [7:0] cpu_wdata_in,
    input wire cpu_wr_in,
    input wire cpu_rd_in,
    output reg [7:0] cpu_rdata_out,
    output wire int_n_out,
    input wire frame_tick_in,
    input wire rx_fdl_valid_in,
    input wire rx_fdl_bit_in,
    input wire [4:0] rx_slot_in,
    input wire [2:0] rx_bit_pos_in,
    input wire [23:0] rx_channel_block_map_in,
    output wire rx_hdlc_bit_en_out,
    output wire rx_hdlc_bit_out,
    input wire tx_fdl_slot_in,
    input wire [4:0] tx_slot_in,
    input wire [2:0] tx_bit_pos_in,
    input wire [23:0] tx_channel_block_map_in,
    input wire tx_hdlc_enable_in,
    input wire tx_hdlc_bit_in,
    input wire tx_legacy_bit_in,
    output wire tx_hdlc_bit_en_out,
    output wire tx_fdl_bit_out,
    output wire tx_fdl_from_hdlc_out,
    output wire rx_byte_valid_out,
    input wire rx_byte_ready_in,
    output wire [7:0] rx_byte_data_out,
    output wire rx_byte_fifo_ready_out
);
    // ------------------------------------------------------------
    // channel gate decode
    // ------------------------------------------------------------
    // a frame carries 24 channels; block mode never selects slot numbers above that
    localparam [4:0] NUM_SLOTS = 5'h18;
    // slot numbers follow the channel number field; bit_pos 0 is channel bit 1
    function chan_gate;
        input [7:0] ctl;
        input [7:0] mask;
        input [4:0] slot;
        input [2:0] bit_pos;
        input [23:0] blk_map;
        reg in_chan;
        begin
            if (ctl[`DLCS_CTL_PICK_MODE]) begin
                in_chan = (slot < NUM_SLOTS) ? blk_map[slot] : 1'b0;
            end else begin
                in_chan = (slot == ctl[`DLCS_CTL_NUM_MSB:`DLCS_CTL_NUM_LSB]);
            end
            chan_gate = in_chan & ~mask[bit_pos];
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] rx_ctl_sh_r;
    reg [7:0] rx_mask_sh_r;
    reg [7:0] tx_ctl_sh_r;
    reg [7:0] tx_mask_sh_r;
    reg [7:0] rx_ctl_r;
    reg [7:0] rx_mask_r;
    reg [7:0] tx_ctl_r;
    reg [7:0] tx_mask_r;
    reg [7:0] match_a_r;
    reg [7:0] match_b_r;
    reg [7:0] irq_mask_r;
    reg [7:0] common_r;
    reg [7:0] rx_buf_r;
    reg buf_full_r;
    reg match_hit_r;
    reg [7:0] shift_r;
    reg [3:0] bit_cnt_r;
    reg [2:0] ones_run_r;
    reg [7:0] shift_nxt;
    reg [3:0] bit_cnt_nxt;
    reg [2:0] ones_run_nxt;
    reg byte_done;
    wire [7:0] status_val;
    wire status_rd;
    wire fifo_in_ready;
    wire drop_zero;
    wire byte_hit;

    assign status_val = {3'h0, buf_full_r, 1'b0, match_hit_r, 2'h0};
    assign status_rd = cpu_rd_in & (cpu_addr_in == `DLCS_ADDR_STATUS2);
    // the run count saturates at seven, so six or more ones never pass for five
    assign drop_zero = ~rx_fdl_bit_in & common_r[`DLCS_CC_DESTUFF] &
        (ones_run_r == `DLCS_STUFF_RUN); // R15 R16
    // compare the byte as it completes, so the match flag agrees with the buffer
    assign byte_hit = (shift_nxt == match_a_r) | (shift_nxt == match_b_r); // R14

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            rx_ctl_sh_r <= `DLCS_RST_BYTE;
            rx_mask_sh_r <= `DLCS_RST_BYTE;
            tx_ctl_sh_r <= `DLCS_RST_BYTE;
            tx_mask_sh_r <= `DLCS_RST_BYTE;
            match_a_r <= `DLCS_RST_BYTE;
            match_b_r <= `DLCS_RST_BYTE;
            irq_mask_r <= `DLCS_RST_BYTE;
            common_r <= `DLCS_RST_BYTE;
        end else if (cpu_wr_in) begin
            case (cpu_addr_in)
                `DLCS_ADDR_RX_CTL: rx_ctl_sh_r <= cpu_wdata_in & `DLCS_CTL_WMASK;
                `DLCS_ADDR_RX_MASK: rx_mask_sh_r <= cpu_wdata_in;
                `DLCS_ADDR_TX_CTL: tx_ctl_sh_r <= cpu_wdata_in & `DLCS_CTL_WMASK;
                `DLCS_ADDR_TX_MASK: tx_mask_sh_r <= cpu_wdata_in;
                `DLCS_ADDR_MATCH_A: match_a_r <= cpu_wdata_in; // R19
                `DLCS_ADDR_MATCH_B: match_b_r <= cpu_wdata_in; // R19
                `DLCS_ADDR_IRQMASK2: irq_mask_r <= cpu_wdata_in;
                `DLCS_ADDR_COMMON2: common_r <= cpu_wdata_in;
                default: ;
            endcase
        end
    end

    // a half-written selection never reaches the line mid-frame
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            rx_ctl_r <= `DLCS_RST_BYTE;
            rx_mask_r <= `DLCS_RST_BYTE;
            tx_ctl_r <= `DLCS_RST_BYTE;
            tx_mask_r <= `DLCS_RST_BYTE;
        end else if (frame_tick_in) begin
            rx_ctl_r <= rx_ctl_sh_r; // R20
            rx_mask_r <= rx_mask_sh_r; // R20
            tx_ctl_r <= tx_ctl_sh_r; // R20
            tx_mask_r <= tx_mask_sh_r; // R20
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    // control reads return the written value with bit 6 cleared, which is in force only from the next frame
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            cpu_rdata_out <= 8'h00;
        end else if (cpu_rd_in) begin
            case (cpu_addr_in)
                `DLCS_ADDR_RX_CTL: cpu_rdata_out <= rx_ctl_sh_r;
                `DLCS_ADDR_RX_MASK: cpu_rdata_out <= rx_mask_sh_r;
                `DLCS_ADDR_TX_CTL: cpu_rdata_out <= tx_ctl_sh_r;
                `DLCS_ADDR_TX_MASK: cpu_rdata_out <= tx_mask_sh_r;
                `DLCS_ADDR_RX_BUF: cpu_rdata_out <= rx_buf_r;
                `DLCS_ADDR_MATCH_A: cpu_rdata_out <= match_a_r;
                `DLCS_ADDR_MATCH_B: cpu_rdata_out <= match_b_r;
                `DLCS_ADDR_STATUS2: cpu_rdata_out <= status_val;
                `DLCS_ADDR_IRQMASK2: cpu_rdata_out <= irq_mask_r;
                `DLCS_ADDR_COMMON2: cpu_rdata_out <= common_r;
                default: cpu_rdata_out <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // channel selection
    // ------------------------------------------------------------
    assign rx_hdlc_bit_en_out = rx_ctl_r[`DLCS_CTL_LINK_EN] ? // R01
        chan_gate(rx_ctl_r, rx_mask_r, rx_slot_in, rx_bit_pos_in, rx_channel_block_map_in) : // R02 R03 R04
        rx_fdl_valid_in;
    // the hdlc receiver taps the raw bit, the legacy buffer runs beside it
    assign rx_hdlc_bit_out = rx_fdl_bit_in; // R09

    assign tx_hdlc_bit_en_out = tx_ctl_r[`DLCS_CTL_LINK_EN] ? // R05
        chan_gate(tx_ctl_r, tx_mask_r, tx_slot_in, tx_bit_pos_in, tx_channel_block_map_in) : // R06 R07 R08
        (tx_fdl_slot_in & tx_hdlc_enable_in);
    // hdlc owns the link only when enabled and not moved into DS0 channels
    assign tx_fdl_from_hdlc_out = tx_hdlc_enable_in & ~tx_ctl_r[`DLCS_CTL_LINK_EN];
    assign tx_fdl_bit_out = tx_fdl_from_hdlc_out ? tx_hdlc_bit_in : tx_legacy_bit_in; // R10

    // ------------------------------------------------------------
    // legacy receive buffer and zero destuffer
    // ------------------------------------------------------------
    always @* begin
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        ones_run_nxt = ones_run_r;
        byte_done = 1'b0;
        if (rx_fdl_valid_in) begin
            if (rx_fdl_bit_in) begin
                if (ones_run_r != `DLCS_RUN_SAT) begin
                    ones_run_nxt = ones_run_r + 1'b1;
                end
            end else begin
                ones_run_nxt = 3'h0;
            end
            // exactly five ones then zero: drop it; six or more keep it
            if (drop_zero) begin // R15 R16
                bit_cnt_nxt = bit_cnt_r;
            end else begin
                shift_nxt = {rx_fdl_bit_in, shift_r[7:1]}; // R11 R18
                if (bit_cnt_r == `DLCS_BYTE_BITS - 4'h1) begin
                    bit_cnt_nxt = 4'h0;
                    byte_done = 1'b1;
                end else begin
                    bit_cnt_nxt = bit_cnt_r + 4'h1;
                end
            end
        end
    end

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            shift_r <= `DLCS_RST_BYTE;
            bit_cnt_r <= 4'h0;
            ones_run_r <= 3'h0;
            rx_buf_r <= `DLCS_RST_BYTE;
            buf_full_r <= 1'b0;
            match_hit_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            ones_run_r <= ones_run_nxt;
            if (byte_done) begin
                // an unread byte is simply overwritten
                rx_buf_r <= shift_nxt; // R11 R13
            end
            // set wins over the clear-on-read of the status register
            if (byte_done) begin
                buf_full_r <= 1'b1; // R12
            end else if (status_rd) begin
                buf_full_r <= 1'b0;
            end
            if (byte_done && byte_hit) begin
                match_hit_r <= 1'b1; // R14
            end else if (status_rd) begin
                match_hit_r <= 1'b0;
            end
        end
    end

    // a level, not a pulse: it stays low until a status read or a mask write
    assign int_n_out = ~((buf_full_r & irq_mask_r[`DLCS_ST_BUF_FULL]) | // R12
        (match_hit_r & irq_mask_r[`DLCS_ST_MATCH])); // R14

    // ------------------------------------------------------------
    // byte stream to a downstream consumer
    // ------------------------------------------------------------
    // a byte that meets a full fifo is lost there, though the buffer register still takes it
    assign rx_byte_fifo_ready_out = fifo_in_ready;

    dlcs_fifo #(
        .WIDTH(8),
        .DEPTH(`DLCS_FIFO_DEPTH),
        .AW(`DLCS_FIFO_AW)
    ) u_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(byte_done),
        .in_ready_out(fifo_in_ready),
        .in_data_in(shift_nxt),
        .out_valid_out(rx_byte_valid_out),
        .out_ready_in(rx_byte_ready_in),
        .out_data_out(rx_byte_data_out)
    );
endmodule

// ### tb/dlcs_line_model.sv
// line side model: frame timing, slot counters and recovered link bits
module dlcs_line_model (
    input wire clk_in,
    output wire frame_tick_out,
    output wire fdl_slot_out,
    output wire [4:0] slot_out,
    output wire [2:0] pos_out,
    output reg valid_out,
    output wire bit_out
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] cnt = 8'h00;
    reg bit_r = 1'b0;
    // 256 clocks a frame so one frame holds a full sweep of all slots
    assign frame_tick_out = cnt == 8'h00;
    assign fdl_slot_out = frame_tick_out;
    assign {slot_out, pos_out} = cnt;
    // between bits the line toggles, so a stale bit never looks held
    assign bit_out = valid_out ? bit_r : cnt[0];
    initial valid_out = 1'b0;
    always @(posedge clk_in) #1 cnt <= cnt + 8'h01;
    task send_bit(input b);
        begin
            @(posedge clk_in);
            while (cnt != 8'h00) @(posedge clk_in);
            #1 valid_out = 1'b1;
            bit_r = b;
            @(posedge clk_in);
            #1 valid_out = 1'b0;
        end
    endtask
endmodule

// ### tb/dlcs_top_sva.sv
// concurrent checks on the ports of the data link channel select top
module dlcs_top_sva (
    input wire clk_in,
    input wire nrst_in,
    input wire cpu_wr_in,
    input wire cpu_rd_in,
    input wire [7:0] cpu_rdata_out,
    input wire int_n_out,
    input wire rx_fdl_valid_in,
    input wire rx_fdl_bit_in,
    input wire rx_hdlc_bit_out,
    input wire tx_hdlc_enable_in,
    input wire tx_hdlc_bit_in,
    input wire tx_legacy_bit_in,
    input wire tx_fdl_bit_out,
    input wire tx_fdl_from_hdlc_out,
    input wire rx_byte_valid_out,
    input wire rx_byte_ready_in,
    input wire [7:0] rx_byte_data_out,
    input wire rx_byte_fifo_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst_in |=> int_n_out && cpu_rdata_out == 8'h00 && !rx_byte_valid_out) else $error("reset state");
    a_rdata_hold: assert property (!cpu_rd_in |=> $stable(cpu_rdata_out)) else $error("read data moved");
    a_rx_shared: assert property (rx_hdlc_bit_out == rx_fdl_bit_in) else $error("rx bit not shared");
    a_tx_one_source: assert property (
        tx_fdl_bit_out == (tx_fdl_from_hdlc_out ? tx_hdlc_bit_in : tx_legacy_bit_in)) else $error("tx mux");
    a_tx_owner: assert property (tx_fdl_from_hdlc_out |-> tx_hdlc_enable_in) else $error("tx owner");
    a_full_valid: assert property (!rx_byte_fifo_ready_out |-> rx_byte_valid_out) else $error("full but empty");
    a_fifo_hold: assert property (rx_byte_valid_out && !rx_byte_ready_in
        |=> rx_byte_valid_out && $stable(rx_byte_data_out)) else $error("fifo head moved");
    a_int_cause: assert property (
        $fell(int_n_out) |-> $past(rx_fdl_valid_in) || $past(cpu_wr_in)) else $error("int without cause");
    a_int_clear: assert property (
        $rose(int_n_out) |-> $past(cpu_rd_in) || $past(cpu_wr_in)) else $error("int cleared alone");
    a_byte_push: assert property (
        $rose(rx_byte_valid_out) |-> $past(rx_fdl_valid_in)) else $error("byte without bit");
    c_int_low: cover property (!int_n_out);
    c_fifo_full: cover property (!rx_byte_fifo_ready_out);
    c_hdlc_owner: cover property (tx_fdl_from_hdlc_out);
endmodule
bind dlcs_top dlcs_top_sva u_sva (.clk_in, .nrst_in, .cpu_wr_in, .cpu_rd_in, .cpu_rdata_out, .int_n_out,
    .rx_fdl_valid_in, .rx_fdl_bit_in, .rx_hdlc_bit_out, .tx_hdlc_enable_in, .tx_hdlc_bit_in, .tx_legacy_bit_in,
    .tx_fdl_bit_out, .tx_fdl_from_hdlc_out, .rx_byte_valid_out, .rx_byte_ready_in, .rx_byte_data_out,
    .rx_byte_fifo_ready_out);

// ### tb/data_link_channel_select_fdl_rx_bench.sv
// self-checking bench of the data link channel select block
module data_link_channel_select_fdl_rx_bench;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk_in = 1'b0, nrst_in = 1'b0, cpu_wr_in = 1'b0, cpu_rd_in = 1'b0, rx_byte_ready_in = 1'b0;
    reg tx_hdlc_enable_in = 1'b0, tx_hdlc_bit_in = 1'b0, tx_legacy_bit_in = 1'b0;
    reg [7:0] cpu_addr_in = 8'h00, cpu_wdata_in = 8'h00, d, rc, tc, rm, tm, arc, atc, arm, atm;
    reg [23:0] rx_channel_block_map_in = 24'h000000, tx_channel_block_map_in = 24'h000000;
    reg [15:0] v;
    reg [7:0] q[$];
    wire [7:0] cpu_rdata_out, rx_byte_data_out;
    wire [4:0] rx_slot_in, tx_slot_in;
    wire [2:0] rx_bit_pos_in, tx_bit_pos_in;
    wire int_n_out, frame_tick_in, rx_fdl_valid_in, rx_fdl_bit_in, rx_hdlc_bit_en_out, rx_hdlc_bit_out;
    wire tx_fdl_slot_in, tx_hdlc_bit_en_out, tx_fdl_bit_out, tx_fdl_from_hdlc_out;
    wire rx_byte_valid_out, rx_byte_fifo_ready_out;
    integer err_count = 0, samples_checked = 0, i, k;
    assign tx_slot_in = rx_slot_in;
    assign tx_bit_pos_in = rx_bit_pos_in;
    dlcs_top dut (.clk_in, .nrst_in, .cpu_addr_in, .cpu_wdata_in, .cpu_wr_in, .cpu_rd_in, .cpu_rdata_out,
        .int_n_out, .frame_tick_in, .rx_fdl_valid_in, .rx_fdl_bit_in, .rx_slot_in, .rx_bit_pos_in,
        .rx_channel_block_map_in, .rx_hdlc_bit_en_out, .rx_hdlc_bit_out, .tx_fdl_slot_in, .tx_slot_in,
        .tx_bit_pos_in, .tx_channel_block_map_in, .tx_hdlc_enable_in, .tx_hdlc_bit_in, .tx_legacy_bit_in,
        .tx_hdlc_bit_en_out, .tx_fdl_bit_out, .tx_fdl_from_hdlc_out, .rx_byte_valid_out, .rx_byte_ready_in,
        .rx_byte_data_out, .rx_byte_fifo_ready_out);
    dlcs_line_model line (.clk_in, .frame_tick_out(frame_tick_in), .fdl_slot_out(tx_fdl_slot_in),
        .slot_out(rx_slot_in), .pos_out(rx_bit_pos_in), .valid_out(rx_fdl_valid_in), .bit_out(rx_fdl_bit_in));
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in) #1 {tx_hdlc_bit_in, tx_legacy_bit_in} <= 2'($urandom);
    task chk(input [7:0] got, exp);
        begin
            samples_checked++;
            if (got !== exp) begin
                err_count++;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task chkb(input got, exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task wr(input [7:0] a, input [7:0] x);
        begin
            @(posedge clk_in);
            #1 {cpu_addr_in, cpu_wdata_in, cpu_wr_in} = {a, x, 1'b1};
            @(posedge clk_in);
            #1 cpu_wr_in = 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [7:0] x);
        begin
            @(posedge clk_in);
            #1 {cpu_addr_in, cpu_rd_in} = {a, 1'b1};
            @(posedge clk_in);
            #1 cpu_rd_in = 1'b0;
            x = cpu_rdata_out;
        end
    endtask
    task do_reset;
        begin
            @(posedge clk_in);
            #1 nrst_in = 1'b0;
            repeat (2) @(posedge clk_in);
            #1 nrst_in = 1'b1;
        end
    endtask
    task send_bits(input [15:0] b, input integer n);
        integer j;
        for (j = 0; j < n; j++) line.send_bit(b[j]);
    endtask
    // single channel compares the slot, block mode indexes the map
    function automatic sel(input [7:0] c, m, input [23:0] map);
        sel = !m[rx_bit_pos_in] && (c[5] ? rx_slot_in < 5'h18 && map[rx_slot_in] : rx_slot_in == c[4:0]);
    endfunction
    // kept bits of a stream that starts with no run of ones behind it
    function automatic [7:0] kept_byte(input [15:0] b, input integer n);
        integer j, run, c;
        begin
            run = 0;
            c = 0;
            kept_byte = 8'h00;
            for (j = 0; j < n; j++) begin
                if (!(!b[j] && run == 5) && c < 8) begin
                    kept_byte[c] = b[j];
                    c++;
                end
                run = b[j] ? run + 1 : 0;
            end
        end
    endfunction
    task tally_and_finish;
        begin
            if (err_count == 0 && samples_checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #2400000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        k = $urandom(32'h09cb2363);
        repeat (2) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        for (k = 0; k < 5; k++) begin
            tc = (k == 4) ? 8'h55 : 8'h90 + 8'(k);
            rd(tc, rc);
            chk(rc, 8'h00);
            d = $urandom;
            wr(tc, d);
            rd(tc, rc);
            chk(rc, (k == 4) ? 8'h00 : (k[0] ? d : d & 8'hbf));
        end
        do_reset;
        rx_channel_block_map_in = 24'($urandom);
        tx_channel_block_map_in = 24'($urandom);
        {arc, atc, arm, atm} = 32'h00000000;
        for (k = 0; k < 4; k++) begin
            while (rx_slot_in != 5'h00 || rx_bit_pos_in != 3'h1) @(posedge clk_in);
            {rc, tc, rm, tm} = $urandom;
            rc[7:5] = {k != 2, 1'b0, k[0]};
            tc[7:5] = {k != 2, 1'b0, !k[0]};
            wr(8'h90, rc);
            wr(8'h91, rm);
            wr(8'h92, tc);
            wr(8'h93, tm);
            tx_hdlc_enable_in = (k == 2) | 1'($urandom);
            for (i = 0; i < 512; i++) begin
                @(posedge clk_in);
                if (frame_tick_in) {arc, atc, arm, atm} = {rc, tc, rm, tm};
                @(negedge clk_in);
                chkb(rx_hdlc_bit_en_out, arc[7] && sel(arc, arm, rx_channel_block_map_in));
                if (atc[7]) chkb(tx_hdlc_bit_en_out, sel(atc, atm, tx_channel_block_map_in));
                else chkb(tx_hdlc_bit_en_out, tx_fdl_slot_in && tx_hdlc_enable_in);
                chkb(tx_fdl_from_hdlc_out, !atc[7] && tx_hdlc_enable_in);
                chkb(tx_fdl_bit_out, (!atc[7] && tx_hdlc_enable_in) ? tx_hdlc_bit_in : tx_legacy_bit_in);
            end
        end
        do_reset;
        wr(8'h1b, 8'h14);
        for (k = 0; k < 9; k++) begin
            d = $urandom;
            if (k == 8) wr(8'h2a, d);
            if (k < 8) q.push_back(d);
            send_bits({8'h00, d}, 8);
        end
        chkb(rx_byte_fifo_ready_out, 1'b0);
        chkb(int_n_out, 1'b0);
        wr(8'h1b, 8'h00);
        chkb(int_n_out, 1'b1);
        rd(8'h28, rc);
        chk(rc, d);
        rd(8'h17, rc);
        chk(rc, 8'h14);
        rd(8'h17, rc);
        chk(rc, 8'h00);
        rx_byte_ready_in = 1'b1;
        for (i = 0; i < 8; i++) begin
            @(negedge clk_in);
            chkb(rx_byte_valid_out, 1'b1);
            chk(rx_byte_data_out, q.pop_front());
        end
        @(negedge clk_in);
        chkb(rx_byte_valid_out, 1'b0);
        do_reset;
        wr(8'h1a, 8'h01);
        for (k = 0; k < 2; k++) begin
            v = k ? 16'h003f : 16'h015f;
            send_bits(v, 9 - k);
            rd(8'h28, rc);
            chk(rc, kept_byte(v, 9 - k));
        end
        tally_and_finish;
    end
endmodule
